// ===== verilog/ieb_top.sv
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ns

// What this block does
// - an enable bit at one passes its source's request, at zero blocks it
// - unimplemented enable bits read zero and ignore writes
// - implemented enable bits are read/write and clear to zero at reset
// - second word bits 15..8 hold serial2, pin2, timers, compares, dma2 enables
// - second word low byte holds capture, pin1, change, comparator, i2c enables
// - third word holds dma4, parallel port, dma3, can and spi2 enables
// - fourth word holds calendar enable at bit 14, dma5 at bit 13
// - first word bits 2..0 hold compare1, capture1 and pin0 enables
// - without a can controller the can enables stay off regardless of writes
// - each source's flag reads one when it has raised a request
// - each source has a three-bit priority; zero disables, seven is highest
module ieb_top (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [ieb_pkg::ADR_W-1:0] wb_adr_in,
   input wire logic [ieb_pkg::SEL_W-1:0] wb_sel_in,
   input wire logic [ieb_pkg::DAT_W-1:0] wb_dat_in,
   output logic [ieb_pkg::DAT_W-1:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic can_present_in,
   input wire logic [ieb_pkg::N_SRC-1:0] src_flag_in,
   output logic [ieb_pkg::N_SRC-1:0] irq_en_out,
   output logic [ieb_pkg::N_SRC-1:0] irq_req_out,
   output logic [ieb_pkg::N_SRC*ieb_pkg::PRIO_W-1:0] irq_prio_out
);

   ////////////////////////////////////////////////////////////////////////////
   // state of the bus slave and the priority fields

   typedef struct packed {
      ieb_pkg::ieb_bus_state_t bus_r;
      logic [ieb_pkg::DAT_W-1:0] dat_r;
      logic [ieb_pkg::N_SRC-1:0][ieb_pkg::PRIO_W-1:0] prio_r;
   } ieb_top_state_t;

   ieb_top_state_t st_r;
   ieb_top_state_t st_nxt;

   logic [ieb_pkg::IDX_W-1:0] idx;
   logic req_live;
   logic wr_commit;
   logic [ieb_pkg::N_WORDS-1:0] en_wr;
   logic [ieb_pkg::N_WORDS*ieb_pkg::REG_W-1:0] en_all;
   logic [ieb_pkg::N_WORDS*ieb_pkg::REG_W-1:0] lock_all;
   logic [ieb_pkg::N_SRC-1:0] prio_live;
   logic [ieb_pkg::DAT_W-1:0] rd_data;
   logic [3:0] prio_reg;
   logic [ieb_pkg::IDX_W-1:0] prio_off;
   logic [ieb_pkg::IDX_W-1:0] en_off;
   logic [ieb_pkg::IDX_W-1:0] flag_off;

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   // word index; bits 1..0 of the byte address are ignored
   assign idx = wb_adr_in[ieb_pkg::ADR_W-1:2];
   assign req_live = wb_cyc_in & wb_stb_in;
   // writes land at the edge where ack is seen high, never earlier
   assign wr_commit = req_live & wb_we_in & (st_r.bus_r == ieb_pkg::IEB_ACK);
   assign en_off = idx - ieb_pkg::IDX_EN0;
   assign flag_off = idx - ieb_pkg::IDX_FLAG0;
   assign prio_off = idx - ieb_pkg::IDX_PRIO0;
   assign prio_reg = prio_off[3:0];

   // one strobe per enable word
   always_comb begin
      en_wr = '0;
      if (wr_commit && idx <= ieb_pkg::IDX_EN3) begin
         en_wr[en_off[1:0]] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // can variant handling

   // without the can controller its enables are locked off; a live level,
   // so a part that strapped this low can never slip a can request through
   always_comb begin
      lock_all = '0;
      if (!can_present_in) begin
         lock_all[2*ieb_pkg::REG_W +: ieb_pkg::REG_W] = ieb_pkg::CAN_MASK2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // priority zero disables a source outright

   always_comb begin
      for (int s = 0; s < ieb_pkg::N_SRC; s++) begin
         prio_live[s] = (st_r.prio_r[s] != ieb_pkg::PRIO_OFF);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // the four enable words

   // word 0: pin0 at 0, capture1 at 1, compare1 at 2, rest of low sources above
   ieb_enable_word #(
      .IMPL_MASK(ieb_pkg::EN0_MASK)
   ) u_en0 (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr_in(en_wr[0]),
      .sel_in(wb_sel_in[1:0]),
      .dat_in(wb_dat_in[ieb_pkg::REG_W-1:0]),
      .lock_in(lock_all[0 +: ieb_pkg::REG_W]),
      .flag_in(src_flag_in[0 +: ieb_pkg::REG_W]),
      .prio_live_in(prio_live[0 +: ieb_pkg::REG_W]),
      .en_out(en_all[0 +: ieb_pkg::REG_W]),
      .req_out(irq_req_out[0 +: ieb_pkg::REG_W])
   );

   // word 1: serial2, pins, timers, compares, dma2, captures, i2c; bit 5 empty
   ieb_enable_word #(
      .IMPL_MASK(ieb_pkg::EN1_MASK)
   ) u_en1 (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr_in(en_wr[1]),
      .sel_in(wb_sel_in[1:0]),
      .dat_in(wb_dat_in[ieb_pkg::REG_W-1:0]),
      .lock_in(lock_all[ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .flag_in(src_flag_in[ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .prio_live_in(prio_live[ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .en_out(en_all[ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .req_out(irq_req_out[ieb_pkg::REG_W +: ieb_pkg::REG_W])
   );

   // word 2: dma4, parallel port, dma3, can pair, spi2 pair
   ieb_enable_word #(
      .IMPL_MASK(ieb_pkg::EN2_MASK)
   ) u_en2 (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr_in(en_wr[2]),
      .sel_in(wb_sel_in[1:0]),
      .dat_in(wb_dat_in[ieb_pkg::REG_W-1:0]),
      .lock_in(lock_all[2*ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .flag_in(src_flag_in[2*ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .prio_live_in(prio_live[2*ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .en_out(en_all[2*ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .req_out(irq_req_out[2*ieb_pkg::REG_W +: ieb_pkg::REG_W])
   );

   // word 3: calendar at 14, dma5 at 13, nothing else
   ieb_enable_word #(
      .IMPL_MASK(ieb_pkg::EN3_MASK)
   ) u_en3 (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr_in(en_wr[3]),
      .sel_in(wb_sel_in[1:0]),
      .dat_in(wb_dat_in[ieb_pkg::REG_W-1:0]),
      .lock_in(lock_all[3*ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .flag_in(src_flag_in[3*ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .prio_live_in(prio_live[3*ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .en_out(en_all[3*ieb_pkg::REG_W +: ieb_pkg::REG_W]),
      .req_out(irq_req_out[3*ieb_pkg::REG_W +: ieb_pkg::REG_W])
   );

   assign irq_en_out = en_all;

   ////////////////////////////////////////////////////////////////////////////
   // read mux, sampled into a flop one cycle before ack

   always_comb begin
      rd_data = '0;
      if (idx <= ieb_pkg::IDX_EN3) begin
         // unimplemented positions already read zero from the word
         rd_data[ieb_pkg::REG_W-1:0] = en_all[en_off[1:0]*ieb_pkg::REG_W +: ieb_pkg::REG_W];
      end else if (idx <= ieb_pkg::IDX_FLAG3) begin
         // flags are the live source levels, masked to implemented sources
         rd_data[ieb_pkg::REG_W-1:0] =
            src_flag_in[flag_off[1:0]*ieb_pkg::REG_W +: ieb_pkg::REG_W] &
            ieb_pkg::EN_MASK_ALL[flag_off[1:0]*ieb_pkg::REG_W +: ieb_pkg::REG_W];
      end else if (idx <= ieb_pkg::IDX_PRIO15) begin
         for (int j = 0; j < ieb_pkg::PRIO_PER_REG; j++) begin
            rd_data[j*ieb_pkg::PRIO_FIELD_STRIDE +: ieb_pkg::PRIO_W] =
               st_r.prio_r[prio_reg*ieb_pkg::PRIO_PER_REG + j];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state: wishbone classic handshake and priority writes

   // trade-off: one wait state for a registered read path, so ack and data
   // never ride a long combinational path from the address pins
   always_comb begin
      st_nxt = st_r;
      case (st_r.bus_r)
         ieb_pkg::IEB_IDLE: begin
            if (req_live) begin
               st_nxt.bus_r = ieb_pkg::IEB_ACK;
               st_nxt.dat_r = wb_we_in ? '0 : rd_data;
            end
         end
         ieb_pkg::IEB_ACK: begin
            // ack lasts exactly one cycle; master must drop stb after it
            st_nxt.bus_r = ieb_pkg::IEB_IDLE;
         end
         default: begin
            st_nxt.bus_r = ieb_pkg::IEB_IDLE;
         end
      endcase
      // priority fields of implemented sources; low byte then high byte
      if (wr_commit && idx >= ieb_pkg::IDX_PRIO0 && idx <= ieb_pkg::IDX_PRIO15) begin
         for (int j = 0; j < ieb_pkg::PRIO_PER_REG; j++) begin
            if (wb_sel_in[j/2] &&
                ieb_pkg::EN_MASK_ALL[prio_reg*ieb_pkg::PRIO_PER_REG + j]) begin
               st_nxt.prio_r[prio_reg*ieb_pkg::PRIO_PER_REG + j] =
                  wb_dat_in[j*ieb_pkg::PRIO_FIELD_STRIDE +: ieb_pkg::PRIO_W];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r.bus_r <= ieb_pkg::IEB_IDLE;
         st_r.dat_r <= '0;
         for (int s = 0; s < ieb_pkg::N_SRC; s++) begin
            // unimplemented sources keep a zero field so they read zero
            st_r.prio_r[s] <= ieb_pkg::EN_MASK_ALL[s] ? ieb_pkg::PRIO_RESET : ieb_pkg::PRIO_OFF;
         end
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // ack is dropped at once if the master abandons the cycle
   assign wb_ack_out = (st_r.bus_r == ieb_pkg::IEB_ACK) & req_live;
   assign wb_dat_out = st_r.dat_r;
   assign irq_prio_out = st_r.prio_r;

endmodule // ieb_top

// ===== shared/ieb_pkg.sv
package ieb_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;
   localparam int REG_W = 16;
   localparam int N_WORDS = 4;
   localparam int N_SRC = 64;
   localparam int PRIO_W = 3;
   localparam int PRIO_PER_REG = 4;
   localparam int N_PRIO_REGS = 16;
   localparam int IDX_W = 6;

   ////////////////////////////////////////////////////////////////////////////
   // register word indices (byte address is four times the index)
   localparam logic [IDX_W-1:0] IDX_EN0 = 6'h00;
   localparam logic [IDX_W-1:0] IDX_EN3 = 6'h03;
   localparam logic [IDX_W-1:0] IDX_FLAG0 = 6'h04;
   localparam logic [IDX_W-1:0] IDX_FLAG3 = 6'h07;
   localparam logic [IDX_W-1:0] IDX_PRIO0 = 6'h08;
   localparam logic [IDX_W-1:0] IDX_PRIO15 = 6'h17;
   localparam logic [ADR_W-1:0] ADR_EN0 = 8'h00;
   localparam logic [ADR_W-1:0] ADR_EN1 = 8'h04;
   localparam logic [ADR_W-1:0] ADR_EN2 = 8'h08;
   localparam logic [ADR_W-1:0] ADR_EN3 = 8'h0c;
   localparam logic [ADR_W-1:0] ADR_FLAG0 = 8'h10;
   localparam logic [ADR_W-1:0] ADR_PRIO0 = 8'h20;

   ////////////////////////////////////////////////////////////////////////////
   // implemented bits of each enable word; the rest read zero
   localparam logic [REG_W-1:0] EN0_MASK = 16'h7fff;
   localparam logic [REG_W-1:0] EN1_MASK = 16'hffdf;
   localparam logic [REG_W-1:0] EN2_MASK = 16'h601f;
   localparam logic [REG_W-1:0] EN3_MASK = 16'h6000;
   localparam logic [REG_W-1:0] EN_RESET = 16'h0000;
   localparam logic [N_WORDS*REG_W-1:0] EN_MASK_ALL = {EN3_MASK, EN2_MASK, EN1_MASK, EN0_MASK};

   ////////////////////////////////////////////////////////////////////////////
   // enable bit positions within their word
   localparam int EXTPIN0_IRQ_EN = 0;
   localparam int CAP1_IRQ_EN = 1;
   localparam int CMP1_IRQ_EN = 2;
   localparam int I2C_SLAVE_IRQ_EN = 0;
   localparam int I2C_MASTER_IRQ_EN = 1;
   localparam int COMPARATOR_IRQ_EN = 2;
   localparam int PIN_CHANGE_IRQ_EN = 3;
   localparam int EXTPIN1_IRQ_EN = 4;
   localparam int CAP7_IRQ_EN = 6;
   localparam int CAP8_IRQ_EN = 7;
   localparam int DMA_CH2_DONE_IRQ_EN = 8;
   localparam int CMP3_IRQ_EN = 9;
   localparam int CMP4_IRQ_EN = 10;
   localparam int TIMER4_IRQ_EN = 11;
   localparam int TIMER5_IRQ_EN = 12;
   localparam int EXTPIN2_IRQ_EN = 13;
   localparam int SERIAL2_RX_IRQ_EN = 14;
   localparam int SERIAL2_TX_IRQ_EN = 15;
   localparam int SPI2_ERROR_IRQ_EN = 0;
   localparam int SPI2_EVENT_IRQ_EN = 1;
   localparam int CAN_RX_READY_IRQ_EN = 2;
   localparam int CAN_EVENT_IRQ_EN = 3;
   localparam int DMA_CH3_DONE_IRQ_EN = 4;
   localparam int PARALLEL_PORT_IRQ_EN = 13;
   localparam int DMA_CH4_DONE_IRQ_EN = 14;
   localparam int DMA_CH5_DONE_IRQ_EN = 13;
   localparam int CALENDAR_IRQ_EN = 14;

   // can bits of the third enable word, held off when no can controller
   localparam logic [REG_W-1:0] CAN_MASK2 = 16'h000c;

   ////////////////////////////////////////////////////////////////////////////
   // priority fields: bits 4j+2..4j of a priority word, bit 4j+3 reads zero
   localparam int PRIO_FIELD_STRIDE = 4;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
   localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;

   typedef enum logic [0:0] {
      IEB_IDLE = 1'b0,
      IEB_ACK = 1'b1
   } ieb_bus_state_t;
endpackage

// ===== verilog/ieb_enable_word.sv
`timescale 1ns/1ns
// one 16-bit enable word with its request gating
module ieb_enable_word #(
   parameter logic [ieb_pkg::REG_W-1:0] IMPL_MASK = 16'hffff
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wr_in,
   input wire logic [1:0] sel_in,
   input wire logic [ieb_pkg::REG_W-1:0] dat_in,
   input wire logic [ieb_pkg::REG_W-1:0] lock_in,
   input wire logic [ieb_pkg::REG_W-1:0] flag_in,
   input wire logic [ieb_pkg::REG_W-1:0] prio_live_in,
   output logic [ieb_pkg::REG_W-1:0] en_out,
   output logic [ieb_pkg::REG_W-1:0] req_out
);
   typedef struct packed {
      logic [ieb_pkg::REG_W-1:0] en_r;
   } ieb_word_state_t;

   ieb_word_state_t st_r;
   ieb_word_state_t st_nxt;
   logic [ieb_pkg::REG_W-1:0] lane_mask;

   ////////////////////////////////////////////////////////////////////////////
   // byte-lane write, only implemented bits take data
   always_comb begin
      lane_mask = {{8{sel_in[1]}}, {8{sel_in[0]}}};
      st_nxt = st_r;
      if (wr_in) begin
         st_nxt.en_r = (st_r.en_r & ~lane_mask) | (dat_in & lane_mask & IMPL_MASK);
      end
      // locked bits never take a one, whatever was written
      st_nxt.en_r = st_nxt.en_r & ~lock_in;
   end

   // power-on clear so every source starts disabled
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= '{en_r: ieb_pkg::EN_RESET};
      end else begin
         st_r <= st_nxt;
      end
   end

   // lock masks the output at once, so no locked request slips out for a cycle
   assign en_out = st_r.en_r & IMPL_MASK & ~lock_in;
   // flag passes only with enable set and a live priority
   assign req_out = flag_in & en_out & prio_live_in;
endmodule // ieb_enable_word

// ===== tb/ieb_top_asserts.sv
`timescale 1ns/1ns
////////////////////////////////////////
// port-level checks of the enable bank
module ieb_top_asserts (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [ieb_pkg::ADR_W-1:0] wb_adr_in,
   input wire logic [ieb_pkg::SEL_W-1:0] wb_sel_in,
   input wire logic [ieb_pkg::DAT_W-1:0] wb_dat_in,
   input wire logic [ieb_pkg::DAT_W-1:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic can_present_in,
   input wire logic [ieb_pkg::N_SRC-1:0] src_flag_in,
   input wire logic [ieb_pkg::N_SRC-1:0] irq_en_out,
   input wire logic [ieb_pkg::N_SRC-1:0] irq_req_out,
   input wire logic [ieb_pkg::N_SRC*ieb_pkg::PRIO_W-1:0] irq_prio_out
);
   logic [ieb_pkg::N_SRC-1:0] prio_nz;
   // zero priority holds a source off even when enabled
   always_comb begin
      for (int s = 0; s < ieb_pkg::N_SRC; s++) begin
         prio_nz[s] = |irq_prio_out[3*s +: 3];
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // request appears, then a full write to the second word
   sequence req_s;
      $rose(wb_cyc_in && wb_stb_in);
   endsequence
   sequence en1_wr_s;
      wb_ack_out && wb_we_in && wb_adr_in == ieb_pkg::ADR_EN1 && wb_sel_in[1:0] == 2'h3;
   endsequence
   ack_one_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held past one cycle");
   ack_wait_a: assert property (req_s |=> wb_ack_out)
      else $error("ack missing one cycle after request");
   req_gate_a: assert property (
      irq_req_out == (src_flag_in & irq_en_out & prio_nz))
      else $error("request not flag and enable");
   unimpl_zero_a: assert property ((irq_en_out & ~ieb_pkg::EN_MASK_ALL) == 64'h0)
      else $error("unimplemented enable bit set");
   can_off_a: assert property (!can_present_in [*2] |-> irq_en_out[35:34] == 2'h0)
      else $error("can enable on without can");
   upper_zero_a: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0)
      else $error("upper read half not zero");
   en_hold_a: assert property (!(wb_ack_out && wb_we_in)
      |=> (!$stable(can_present_in) || $stable(irq_en_out)))
      else $error("enables moved without a write");
   en1_write_a: assert property (en1_wr_s
      |=> irq_en_out[31:16] == ($past(wb_dat_in[15:0]) & ieb_pkg::EN1_MASK))
      else $error("second word write not stored");
   en_read_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in == ieb_pkg::ADR_EN3
      |-> wb_dat_out[15:0] == irq_en_out[63:48])
      else $error("fourth word read mismatch");
endmodule // ieb_top_asserts

// ===== tb/ieb_arb_model.sv
`timescale 1ns/1ns
////////////////////////////////////////
// far-side priority pick, lowest index wins a tie
module ieb_arb_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [ieb_pkg::N_SRC-1:0] req_in,
   input wire logic [ieb_pkg::N_SRC*ieb_pkg::PRIO_W-1:0] prio_in,
   output logic [ieb_pkg::IDX_W-1:0] win_out,
   output logic win_vld_out
);
   logic [2:0] best;
   logic [5:0] idx;
   // scan down so equal priorities leave the lowest source
   always_comb begin
      best = 3'h0;
      idx = 6'h0;
      for (int s = ieb_pkg::N_SRC - 1; s >= 0; s--) begin
         if (req_in[s] && prio_in[3*s +: 3] != 3'h0 && prio_in[3*s +: 3] >= best) begin
            best = prio_in[3*s +: 3];
            idx = 6'(s);
         end
      end
   end
   // registered so the core sees a clean pick
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         win_out <= 6'h0;
         win_vld_out <= 1'b0;
      end else begin
         win_out <= idx;
         win_vld_out <= best != 3'h0;
      end
   end
endmodule // ieb_arb_model

// ===== tb/ieb_top_tb_top.sv
`timescale 1ns/1ns
module ieb_top_tb_top;
   logic clk_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, can_present_in, win_vld;
   logic [7:0] wb_adr_in;
   logic [3:0] wb_sel_in;
   logic [31:0] wb_dat_in, wb_dat_out;
   logic [63:0] src_flag_in, irq_en_out, irq_req_out;
   logic [191:0] irq_prio_out;
   logic [5:0] win;
   logic [15:0] en_m [4];
   logic [2:0] pr_m [64];
   int errors, compares;
   ieb_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
      .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
      .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
      .can_present_in(can_present_in), .src_flag_in(src_flag_in), .irq_en_out(irq_en_out),
      .irq_req_out(irq_req_out), .irq_prio_out(irq_prio_out));
   ieb_arb_model arb_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(irq_req_out),
      .prio_in(irq_prio_out), .win_out(win), .win_vld_out(win_vld));
   ////////////////////////////////////////
   // classic single wishbone cycle, released at the ack edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r);
      @(posedge clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_sel_in <= s;
      wb_dat_in <= d;
      // hold until ack is seen at a rising edge; only the watchdog ends a hang
      do begin
         @(posedge clk_in);
      end while (wb_ack_out !== 1'b1);
      r = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   // byte lanes merged into the implemented bits only
   function automatic logic [15:0] upd(logic [15:0] o, logic [15:0] v, logic [1:0] s, int w);
      logic [15:0] m;
      m = {{8{s[1]}}, {8{s[0]}}} & ieb_pkg::EN_MASK_ALL[16*w +: 16];
      if (w == 2 && !can_present_in) m &= ~ieb_pkg::CAN_MASK2;
      return (o & ~m) | (v & m);
   endfunction
   function automatic logic [15:0] exp_rd(int k, int p);
      logic [15:0] v;
      v = 16'h0;
      if (k < 4) v = en_m[k];
      if (k == 5) v = src_flag_in[16*(p%4) +: 16] & ieb_pkg::EN_MASK_ALL[16*(p%4) +: 16];
      if (k == 6) begin
         for (int j = 0; j < 4; j++) begin
            v[4*j +: 3] = pr_m[4*p + j];
         end
      end
      return v;
   endfunction
   // priority fields of implemented sources only, lanes as for the enables
   function automatic void upd_pr(int p, logic [15:0] v, logic [1:0] s);
      for (int j = 0; j < 4; j++) begin
         if (s[j/2] && ieb_pkg::EN_MASK_ALL[4*p + j]) begin
            pr_m[4*p + j] = v[4*j +: 3];
         end
      end
   endfunction
   function automatic logic [63:0] nz();
      for (int i = 0; i < 64; i++) begin
         nz[i] = pr_m[i] != 3'h0;
      end
   endfunction
   // far side pick: highest priority, lowest source on a tie
   function automatic logic [6:0] exp_win(logic [63:0] q);
      logic [2:0] b;
      logic [5:0] w;
      b = 3'h0;
      w = 6'h0;
      for (int i = 63; i >= 0; i--) begin
         if (q[i] && pr_m[i] != 3'h0 && pr_m[i] >= b) begin
            b = pr_m[i];
            w = 6'(i);
         end
      end
      return {b != 3'h0, w};
   endfunction
   task automatic end_sim();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // a hang costs far more than the ~600 cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_in);
      errors++;
      end_sim();
   end
   initial begin
      int k, p;
      logic [63:0] q, e;
      logic [31:0] d, r;
      logic [3:0] s;
      logic [7:0] a;
      {rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_sel_in, wb_dat_in} = '0;
      can_present_in = 1'b1;
      src_flag_in = '1;
      en_m = '{default: 16'h0};
      for (int i = 0; i < 64; i++) begin
         pr_m[i] = ieb_pkg::EN_MASK_ALL[i] ? ieb_pkg::PRIO_RESET : ieb_pkg::PRIO_OFF;
      end
      errors = 0;
      compares = 0;
      void'($urandom(32'h7ae089fb));
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      @(negedge clk_in);
      chk("en_reset", 64'h0, irq_en_out);
      for (int i = 0; i < 64; i++) begin
         chk("prio_reset", ieb_pkg::EN_MASK_ALL[i] ? 3'h4 : 3'h0, irq_prio_out[3*i +: 3]);
      end
      // zero priority on sources 0 and 1, then enable the low three bits
      wb(1'b1, ieb_pkg::ADR_PRIO0, 32'h0, 4'h1, r);
      pr_m[0] = 3'h0;
      pr_m[1] = 3'h0;
      wb(1'b1, ieb_pkg::ADR_EN0, 32'h7, 4'h3, r);
      en_m[0] = 16'h7;
      wb(1'b1, ieb_pkg::ADR_EN1, 32'hffffffff, 4'hf, r);
      en_m[1] = ieb_pkg::EN1_MASK;
      @(negedge clk_in);
      chk("req_gate", 64'h4, irq_req_out & 64'hffff);
      // random traffic over every word, unmapped and read-only places
      for (int i = 0; i < 80; i++) begin
         k = $urandom % 7;
         p = $urandom % 16;
         d = $urandom;
         s = 4'($urandom);
         @(posedge clk_in);
         src_flag_in <= {$urandom, $urandom};
         can_present_in <= ($urandom % 4) != 0;
         @(negedge clk_in);
         if (!can_present_in) en_m[2] &= ~ieb_pkg::CAN_MASK2;
         a = (k < 4) ? 8'(k * 4) : (k == 4) ? 8'hf0 :
            (k == 5) ? ieb_pkg::ADR_FLAG0 + 8'(4 * (p % 4)) : ieb_pkg::ADR_PRIO0 + 8'(4 * p);
         wb(1'b1, a, d, s, r);
         if (k < 4) en_m[k] = upd(en_m[k], d[15:0], s[1:0], k);
         if (k == 6) upd_pr(p, d[15:0], s[1:0]);
         wb(1'b0, a, 32'h0, 4'hf, r);
         @(negedge clk_in);
         e = {en_m[3], en_m[2], en_m[1], en_m[0]};
         q = src_flag_in & e & nz();
         chk("read", {48'h0, exp_rd(k, p)}, {32'h0, r});
         chk("en", e, irq_en_out);
         chk("req", q, irq_req_out);
         chk("win", exp_win(q), {win_vld, win});
      end
      end_sim();
   end
endmodule // ieb_top_tb_top
bind ieb_top ieb_top_asserts chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .can_present_in(can_present_in), .src_flag_in(src_flag_in),
   .irq_en_out(irq_en_out), .irq_req_out(irq_req_out), .irq_prio_out(irq_prio_out));
